// ===== sps_sequencer.sv
// step/direction phase sequencer with latched fault detection
// assumes host pins asynchronous to mclk_i, classic wishbone on mclk_i
`timescale 1ns/10ps
`include "sps_regs.svh"

module sps_sequencer
	import sps_pkg::*;
(
	input  wire logic        mclk_i,              // 200 MHz clock
	input  wire logic        arst_n_i,            // power-on reset, low
	input  wire logic        ce_i,                // clock enable
	input  wire logic        step_clk_i,          // step clock pin
	input  wire logic        edge_select_i,       // 1 rising, 0 both
	input  wire logic        excitation_select_i, // 0 2-phase, 1 1-2
	input  wire logic        direction_select_i,  // 0 fwd, 1 rev
	input  wire logic        reset_n_i,           // reset pin, low
	input  wire logic        enable_i,            // output enable pin
	input  wire logic        pwm_on_i,            // chopper on period
	input  wire logic        flyback_i,           // flyback current seen
	input  wire logic        overcurrent_i,       // current comparator
	input  wire logic        overheat_i,          // substrate comparator
	output logic             phase_a_o,           // phase A drive
	output logic             phase_a_bar_o,       // phase A-bar drive
	output logic             phase_b_o,           // phase B drive
	output logic             phase_b_bar_o,       // phase B-bar drive
	input  wire logic        fault_flag_n_i,      // flag pin level
	output logic             fault_flag_n_o,      // flag drive value
	output logic             fault_flag_n_oe_n_o, // flag enable, low
	output logic [1:0]       fault_type_level_o,  // fault kind
	input  wire logic        wb_cyc_i,            // wishbone cycle
	input  wire logic        wb_stb_i,            // wishbone strobe
	input  wire logic        wb_we_i,             // wishbone write
	input  wire logic [7:0]  wb_adr_i,            // byte address
	input  wire logic [3:0]  wb_sel_i,            // byte lanes
	input  wire logic [31:0] wb_dat_i,            // write data
	output logic [31:0]      wb_dat_o,            // read data
	output logic             wb_ack_o             // acknowledge
);
	//--------------------------------------------------------------
	// functions
	//--------------------------------------------------------------

	// half-step index to {a, a_bar, b, b_bar}; even index is two-phase
	function automatic logic [3:0] phase_of(input logic [2:0] pos);
		logic [3:0] p;
		p = `SPS_PHASE_OFF;
		case (pos)
			3'h0: p = 4'h9;
			3'h1: p = 4'h8;
			3'h2: p = 4'ha;
			3'h3: p = 4'h2;
			3'h4: p = 4'h6;
			3'h5: p = 4'h4;
			3'h6: p = 4'h5;
			default: p = 4'h1;
		endcase
		return p;
	endfunction

	// next index; 2-phase from an odd index moves one to realign
	function automatic logic [2:0] next_pos(input logic [2:0] pos,
	                                        input logic half,
	                                        input logic rev);
		logic [2:0] d;
		d = (half || pos[0]) ? 3'h1 : 3'h2;
		return rev ? 3'(pos - d) : 3'(pos + d);
	endfunction

	//--------------------------------------------------------------
	// pin synchronisation
	//--------------------------------------------------------------
	logic [`SPS_SYNC_W-1:0] raw;
	logic [`SPS_SYNC_W-1:0] syn;

	assign raw = {fault_flag_n_i, overheat_i, overcurrent_i, flyback_i,
	              pwm_on_i, enable_i, reset_n_i, direction_select_i,
	              excitation_select_i, edge_select_i, step_clk_i};

	sps_sync u_sync (
		.mclk_i   (mclk_i),
		.arst_n_i (arst_n_i),
		.ce_i     (ce_i),
		.pins_i   (raw),
		.pins_o   (syn)
	);

	logic step_s;
	logic edge_s;
	logic exc_s;
	logic dir_s;
	logic rst_s;
	logic en_s;
	logic pwm_s;
	logic fly_s;
	logic oc_s;
	logic ot_s;
	logic flag_s;

	assign step_s = syn[`SPS_IN_STEP];
	assign edge_s = syn[`SPS_IN_EDGE];
	assign exc_s  = syn[`SPS_IN_EXC];
	assign dir_s  = syn[`SPS_IN_DIR];
	assign rst_s  = syn[`SPS_IN_RST];
	assign en_s   = syn[`SPS_IN_EN];
	assign pwm_s  = syn[`SPS_IN_PWM];
	assign fly_s  = syn[`SPS_IN_FLY];
	assign oc_s   = syn[`SPS_IN_OC];
	assign ot_s   = syn[`SPS_IN_OT];
	assign flag_s = syn[`SPS_IN_FLAG];

	//--------------------------------------------------------------
	// state and events
	//--------------------------------------------------------------
	sps_state_s st;
	sps_state_s nxt_st;

	logic rise;
	logic fall;
	logic step_ev;
	logic pwm_rise;
	logic pwm_fall;
	logic driving;
	logic wb_req;

	// step edges found by comparing with the previous sample
	assign rise     = step_s && !st.clk_prev;
	assign fall     = !step_s && st.clk_prev;
	assign step_ev  = rise || (fall && !edge_s);
	assign pwm_rise = pwm_s && !st.pwm_prev;
	assign pwm_fall = !pwm_s && st.pwm_prev;
	assign driving  = st.phase != `SPS_PHASE_OFF;
	assign wb_req   = wb_cyc_i && wb_stb_i;

	//--------------------------------------------------------------
	// next-state logic
	//--------------------------------------------------------------
	always_comb begin
		nxt_st          = st;
		nxt_st.clk_prev = step_s;
		nxt_st.pwm_prev = pwm_s;

		if (!rst_s) begin
			// reset pin holds initial A and B-bar position
			nxt_st.pos       = `SPS_POS_INIT;
			// only a reset pulse or the power-on reset clears the latch
			nxt_st.fault     = FT_NONE;
			nxt_st.off_armed = 1'b0;
			nxt_st.fly_seen  = 1'b0;
			nxt_st.blank_cnt = '0;
			nxt_st.step_cnt  = '0;
		end else begin
			// edges ignored while faulted; held while disabled
			if (step_ev && en_s && st.fault == FT_NONE) begin
				// direction and mode at the edge
				nxt_st.pos      = next_pos(st.pos, exc_s, dir_s);
				nxt_st.step_cnt = 16'(st.step_cnt + 16'h0001);
			end

			// blanking count held at zero while off, so a new on period
			// never inherits the expired count of the previous one
			if (!pwm_s) begin
				nxt_st.blank_cnt = '0;
			end else if (st.blank_cnt != `SPS_BLANK_W'(`SPS_BLANK_CYC)) begin
				nxt_st.blank_cnt = `SPS_BLANK_W'(st.blank_cnt + 1'b1);
			end

			// watch flyback across one off period
			if (pwm_fall) begin
				nxt_st.off_armed = driving;
				// flyback in the first off cycle counts: the set wins the restart
				nxt_st.fly_seen  = fly_s;
			end else if (!pwm_s && fly_s) begin
				nxt_st.fly_seen = 1'b1;
			end

			// first fault latches; same-cycle ties favour heat
			if (st.fault == FT_NONE) begin
				if (ot_s && st.det_en[`SPS_CTRL_OVERHEAT]) begin
					nxt_st.fault = FT_OVERHEAT;
				// overcurrent once blanking has run out
				end else if (oc_s && pwm_s && driving &&
				             st.det_en[`SPS_CTRL_OVERCUR] &&
				             st.blank_cnt == `SPS_BLANK_W'(`SPS_BLANK_CYC)) begin
					nxt_st.fault = FT_OVERCUR;
				// open terminal when the off period ends dry
				end else if (pwm_rise && st.off_armed && !st.fly_seen &&
				             driving && st.det_en[`SPS_CTRL_OPEN]) begin
					nxt_st.fault = FT_OPEN;
				end
			end
		end

		// phases off in reset, disable or fault
		if (rst_s && en_s && nxt_st.fault == FT_NONE) begin
			nxt_st.phase = phase_of(nxt_st.pos);
		end else begin
			nxt_st.phase = `SPS_PHASE_OFF;
		end

		// classic wishbone: ack one cycle after the strobe, then drop
		nxt_st.wb_ack = wb_req && !st.wb_ack;
		if (wb_req && !st.wb_ack) begin
			if (wb_adr_i == `SPS_ADR_CTRL) begin
				nxt_st.wb_dat = {29'h0, st.det_en};
			end else if (wb_adr_i == `SPS_ADR_STATUS) begin
				nxt_st.wb_dat = {24'h0, flag_s, en_s, !rst_s, st.pos, st.fault};
			end else if (wb_adr_i == `SPS_ADR_STEPS) begin
				nxt_st.wb_dat = {16'h0, st.step_cnt};
			end else begin
				nxt_st.wb_dat = '0;
			end
		end
		// write lands on the edge where the master sees ack
		if (st.wb_ack && wb_req && wb_we_i && wb_sel_i[0] &&
		    wb_adr_i == `SPS_ADR_CTRL) begin
			nxt_st.det_en = wb_dat_i[2:0];
		end
	end

	// power-on reset clears everything except det_en, which loads all detectors on; ce_i freezes all state
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st        <= '0;
			st.fault  <= FT_NONE;
			st.det_en <= `SPS_CTRL_RESET;
		end else if (ce_i) begin
			st <= nxt_st;
		end
	end

	//--------------------------------------------------------------
	// outputs
	//--------------------------------------------------------------
	assign phase_a_o     = st.phase[3];
	assign phase_a_bar_o = st.phase[2];
	assign phase_b_o     = st.phase[1];
	assign phase_b_bar_o = st.phase[0];

	// open drain: pull low while any fault is latched
	assign fault_flag_n_o      = 1'b0;
	assign fault_flag_n_oe_n_o = st.fault == FT_NONE;
	// type code, level translation is outside the logic
	assign fault_type_level_o  = st.fault;
	assign wb_dat_o            = st.wb_dat;
	assign wb_ack_o            = st.wb_ack;

	//--------------------------------------------------------------
	// assertions
	//--------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_step_ok;
		ce_i && rst_s && en_s && st.fault == FT_NONE && step_ev;
	endsequence

	sequence s_open_end;
		ce_i && rst_s && st.fault == FT_NONE && pwm_rise && st.off_armed
		&& !st.fly_seen && driving && !ot_s && !oc_s
		&& st.det_en == `SPS_CTRL_RESET;
	endsequence

	a_phases_disabled: assert property (
		(ce_i && !en_s) |=> st.phase == `SPS_PHASE_OFF)
		else $error("phases driven while disabled");

	a_hold_disabled: assert property (
		(ce_i && !en_s && rst_s) |=> st.pos == $past(st.pos))
		else $error("position moved while disabled");

	a_reset_initial: assert property (
		(ce_i && !rst_s) ##1 (ce_i && rst_s && en_s && !ot_s)
		|=> st.phase == 4'h9)
		else $error("release not at A and B-bar");

	a_fall_ignored: assert property (
		(ce_i && fall && edge_s) |=> st.pos == $past(st.pos))
		else $error("falling edge stepped in rising mode");

	a_fwd_two_phase: assert property (
		(s_step_ok and (!dir_s && !exc_s && !st.pos[0]))
		|=> st.pos == 3'($past(st.pos) + 3'h2))
		else $error("two-phase forward step wrong");

	a_rev_half_step: assert property (
		(s_step_ok and (dir_s && exc_s))
		|=> st.pos == 3'($past(st.pos) - 3'h1))
		else $error("half-step reverse wrong");

	a_flag_follows: assert property (
		st.fault != FT_NONE |-> !fault_flag_n_oe_n_o && !fault_flag_n_o)
		else $error("fault flag not driven low");

	a_fault_latched: assert property (
		(ce_i && rst_s && st.fault != FT_NONE)
		|=> st.fault == $past(st.fault) && st.phase == `SPS_PHASE_OFF)
		else $error("latched fault changed");

	a_overheat_set: assert property (
		(ce_i && rst_s && ot_s && st.fault == FT_NONE
		 && st.det_en[`SPS_CTRL_OVERHEAT])
		|=> fault_type_level_o == FT_OVERHEAT)
		else $error("overheat not latched");

	a_oc_blanked: assert property (
		(ce_i && rst_s && pwm_rise && st.fault != FT_OVERCUR)
		|=> st.fault != FT_OVERCUR [*8])
		else $error("overcurrent inside blanking");

	a_open_detect: assert property (
		s_open_end |=> st.fault == FT_OPEN)
		else $error("open terminal missed");

	a_wb_ack_pulse: assert property (
		(ce_i && wb_ack_o) |=> !wb_ack_o)
		else $error("ack held two cycles");
endmodule

// ===== sps_regs.svh
// register offsets, field positions and timing counts of the phase sequencer
// assumes inclusion by sps_pkg users only; definitions, no logic
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// clock and timing
`define SPS_CLK_PERIOD_NS 5
`define SPS_BLANK_NS      5500
// blanking rounds up to whole cycles
`define SPS_BLANK_CYC     (((`SPS_BLANK_NS)+(`SPS_CLK_PERIOD_NS)-1)/(`SPS_CLK_PERIOD_NS))
`define SPS_BLANK_W       11

// wishbone register offsets
`define SPS_ADR_CTRL      8'h00
`define SPS_ADR_STATUS    8'h04
`define SPS_ADR_STEPS     8'h08

// ctrl fields: detector enables
`define SPS_CTRL_OPEN     0
`define SPS_CTRL_OVERCUR  1
`define SPS_CTRL_OVERHEAT 2
`define SPS_CTRL_RESET    3'h7

// status fields
`define SPS_ST_FAULT_LO   0
`define SPS_ST_FAULT_HI   1
`define SPS_ST_POS_LO     2
`define SPS_ST_POS_HI     4
`define SPS_ST_IN_RESET   5
`define SPS_ST_ENABLE     6
`define SPS_ST_FLAG_PIN   7

// synchronised input bit positions
`define SPS_SYNC_W        11
`define SPS_IN_STEP       0
`define SPS_IN_EDGE       1
`define SPS_IN_EXC        2
`define SPS_IN_DIR        3
`define SPS_IN_RST        4
`define SPS_IN_EN         5
`define SPS_IN_PWM        6
`define SPS_IN_FLY        7
`define SPS_IN_OC         8
`define SPS_IN_OT         9
`define SPS_IN_FLAG       10

// sequencer
`define SPS_POS_INIT      3'h0
`define SPS_PHASE_OFF     4'h0
`endif

// ===== sps_pkg.sv
// types shared by the phase sequencer modules
// assumes sps_regs.svh for the widths
`include "sps_regs.svh"
package sps_pkg;

	// latched fault kind, also the four-level type output
	typedef enum logic [1:0] {
		FT_NONE,
		FT_OPEN,
		FT_OVERCUR,
		FT_OVERHEAT
	} sps_fault_e;

	typedef struct packed {
		logic [`SPS_SYNC_W-1:0] s1;
		logic [`SPS_SYNC_W-1:0] s2;
	} sps_sync_s;

	typedef struct packed {
		logic                    clk_prev;
		logic [2:0]              pos;
		logic [3:0]              phase;
		sps_fault_e              fault;
		logic                    pwm_prev;
		logic                    off_armed;
		logic                    fly_seen;
		logic [`SPS_BLANK_W-1:0] blank_cnt;
		logic [2:0]              det_en;
		logic [15:0]             step_cnt;
		logic                    wb_ack;
		logic [31:0]             wb_dat;
	} sps_state_s;

endpackage

// ===== sps_sync.sv
// two-flop synchroniser for all pin inputs of the phase sequencer
// assumes pins are asynchronous to mclk_i; stage one feeds stage two only
`timescale 1ns/10ps
`include "sps_regs.svh"
module sps_sync
	import sps_pkg::*;
(
	input  wire logic                   mclk_i,   // system clock
	input  wire logic                   arst_n_i, // async reset, low
	input  wire logic                   ce_i,     // clock enable
	input  wire logic [`SPS_SYNC_W-1:0] pins_i,   // raw pin levels
	output logic      [`SPS_SYNC_W-1:0] pins_o    // synchronised levels
);
	sps_sync_s st;
	sps_sync_s nxt_st;

	// shift one stage per enabled cycle
	always_comb begin
		nxt_st    = st;
		nxt_st.s1 = pins_i;
		nxt_st.s2 = st.s1;
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
		end else if (ce_i) begin
			st <= nxt_st;
		end
	end

	assign pins_o = st.s2;
endmodule

// ===== sps_host_model.sv
// host controller model: makes the step clock for the phase sequencer
// assumes the bench drives reset, mode and direction levels; times in ns
`timescale 1ns/10ps
module sps_host_model #(
	parameter int RST_WAIT_NS = 10000, // settle time after reset release
	parameter int SETUP_NS    = 6250,  // select stability around edges
	parameter int HALF_NS     = 24     // half period of the step clock
) (
	input  wire logic       reset_n_i,  // reset pin level
	input  wire logic [2:0] sel_i,      // edge, excitation, direction
	output logic            step_clk_o  // step clock, idle low
);
	realtime t_rst = 0;
	realtime t_sel = 0;

	// ----------------------------------------
	// timing bookkeeping
	// ----------------------------------------
	initial step_clk_o = 1'b0;
	always @(posedge reset_n_i) t_rst = $realtime;
	always @(sel_i) t_sel = $realtime;

	// one frame of n pulses; the clock stands still outside frames
	task automatic pulses(input int n);
		if ($realtime < t_rst + RST_WAIT_NS) #(t_rst + RST_WAIT_NS - $realtime);
		if ($realtime < t_sel + SETUP_NS) #(t_sel + SETUP_NS - $realtime);
		// odd offset keeps edges off the sampling clock edge
		#1.3;
		// regular pulses at the bench link rate
		for (int i = 0; i < n; i++) begin
			step_clk_o = 1'b1;
			#(HALF_NS);
			step_clk_o = 1'b0;
			// last low time stretched to slow down before stopping
			#((i == n - 1) ? 2 * HALF_NS : HALF_NS);
		end
		#(SETUP_NS);
	endtask
endmodule

// ===== stepper_phase_sequencer_fault_latch_bench.sv
// self-checking bench for the phase sequencer and its fault latch
// assumes sps_host_model makes the step clock; wishbone master lives here
`timescale 1ns/10ps
module stepper_phase_sequencer_fault_latch_bench
	import sps_pkg::*;
;
	logic        mclk_i, arst_n_i, step_clk, edge_sel, exc_sel, dir_sel, rst_n, en;
	logic        ce, pwm, fly, oc, ot, ph_a, ph_ab, ph_b, ph_bb;
	logic        flag_o, flag_oe_n, cyc, stb, we, ack;
	logic [1:0]  ftype, ft_prev;
	logic [3:0]  sel, ph_prev;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat;
	logic [2:0]  idx;
	logic [15:0] steps;
	logic [3:0]  ph_q[$];
	logic [1:0]  ft_q[$];
	logic [31:0] rd_q[$];
	int          err_total, n_checks;
	wire         flag_pin = flag_oe_n ? 1'b1 : flag_o; // pull-up on the flag line
	wire  [3:0]  ph_now   = {ph_a, ph_ab, ph_b, ph_bb};
	logic [3:0]  ph_tab [8] = '{4'h9, 4'h8, 4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1};

	// ----------------------------------------
	// design and host
	// ----------------------------------------
	sps_sequencer i_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce),
		.step_clk_i(step_clk), .edge_select_i(edge_sel), .excitation_select_i(exc_sel),
		.direction_select_i(dir_sel), .reset_n_i(rst_n), .enable_i(en), .pwm_on_i(pwm),
		.flyback_i(fly), .overcurrent_i(oc), .overheat_i(ot), .phase_a_o(ph_a),
		.phase_a_bar_o(ph_ab), .phase_b_o(ph_b), .phase_b_bar_o(ph_bb),
		.fault_flag_n_i(flag_pin), .fault_flag_n_o(flag_o), .fault_flag_n_oe_n_o(flag_oe_n),
		.fault_type_level_o(ftype), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
	sps_host_model i_host (.reset_n_i(rst_n), .sel_i({edge_sel, exc_sel, dir_sel}),
		.step_clk_o(step_clk));

	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one compare per kind of result; each takes the oldest note off its queue
	task automatic cmp_phase();
		cmp("phases", {28'h0, ph_q.size() ? ph_q.pop_front() : 4'hx}, {28'h0, ph_now});
	endtask

	task automatic cmp_type();
		cmp("fault type", {30'h0, ft_q.size() ? ft_q.pop_front() : 2'hx}, {30'h0, ftype});
	endtask

	task automatic cmp_read();
		cmp("read data", rd_q.size() ? rd_q.pop_front() : 32'hxxxx_xxxx, rdat);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// classic single cycle; entered just after a rising edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= {3'($urandom), 1'h1};
		@(posedge mclk_i);
		k = 0;
		while (ack !== 1'b1 && k < 50) begin
			@(posedge mclk_i);
			k++;
		end
		// a lost acknowledge ends the run at once
		if (k == 50) begin
			cmp("wb ack", 32'h0000_0001, 32'h0000_0000);
			report_and_stop();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge mclk_i);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		wb(1'b0, a, 32'h0000_0000);
	endtask

	// notes the phase value of every accepted edge, then lets the host pulse
	task automatic step(input logic live, input int n);
		logic [2:0] d;
		repeat (n * (edge_sel ? 1 : 2)) begin
			if (live) begin
				d = (exc_sel || idx[0]) ? 3'h1 : 3'h2;
				idx = dir_sel ? idx - d : idx + d;
				ph_q.push_back(ph_tab[idx]);
				steps++;
			end
		end
		i_host.pulses(n);
		@(posedge mclk_i);
	endtask

	// pulse on the reset pin; the latch clears and phases restart at A and B-bar
	task automatic rst_pulse(input logic [1:0] was);
		if (was != 2'h0) ft_q.push_back(2'h0);
		ph_q.push_back(4'h9);
		idx = 3'h0;
		steps = 16'h0000;
		rst_n <= 1'b0;
		repeat (4) @(posedge mclk_i);
		rst_n <= 1'b1;
		repeat (10) @(posedge mclk_i);
	endtask

	// ----------------------------------------
	// result monitors: each phase or type change, and each read ack, takes the oldest note
	// ----------------------------------------
	always @(posedge mclk_i) begin
		if (arst_n_i === 1'b1 && ph_now !== ph_prev)
			cmp_phase();
		if (arst_n_i === 1'b1 && ftype !== ft_prev)
			cmp_type();
		if (ack === 1'b1 && we === 1'b0)
			cmp_read();
		ph_prev <= ph_now;
		ft_prev <= ftype;
	end

	// about four and a half times the expected run, well inside the cycle budget
	initial begin
		#400_000;
		err_total++;
		report_and_stop();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		// enable low at power-up, no chopping yet
		{cyc, stb, we, adr, sel, wdat, edge_sel, exc_sel, dir_sel} = '0;
		{rst_n, en, pwm, oc, ot, arst_n_i} = '0;
		{ce, fly, edge_sel} = 3'h7;
		{ph_prev, ft_prev, idx, steps, err_total, n_checks} = '0;
		void'($urandom(8263));
		repeat (6) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		en <= 1'b1;
		repeat (4) @(posedge mclk_i);
		rst_pulse(2'h0);
		rd(8'h00, 32'h0000_0007);
		rd(8'h40, 32'h0000_0000);
		$display("test reset done");
		for (int m = 0; m < 4; m++) begin
			edge_sel <= m[0];
			// half-step first, so two-phase later starts from an odd index when the half-step edge count is odd
			exc_sel <= !m[1];
			dir_sel <= 1'($urandom_range(1, 0));
			@(posedge mclk_i);
			step(1'b1, $urandom_range(5, 1));
		end
		rd(8'h08, {16'h0000, steps});
		rd(8'h04, {24'h00_0000, 3'b110, idx, 2'h0});
		$display("test stepping done");
		ph_q.push_back(4'h0);
		en <= 1'b0;
		repeat (10) @(posedge mclk_i);
		step(1'b0, 2);
		ph_q.push_back(ph_tab[idx]);
		en <= 1'b1;
		repeat (10) @(posedge mclk_i);
		step(1'b1, 1);
		$display("test enable done");
		pwm <= 1'b1;
		oc <= 1'b1;
		repeat (1000) @(posedge mclk_i);
		{oc, pwm} <= 2'b00;
		repeat (20) @(posedge mclk_i);
		pwm <= 1'b1;
		repeat (20) @(posedge mclk_i);
		pwm <= 1'b0;
		wb(1'b1, 8'h00, 32'h0000_0003);
		ot <= 1'b1;
		repeat (10) @(posedge mclk_i);
		ot <= 1'b0;
		repeat (4) @(posedge mclk_i);
		// detectors off: random chopper, comparators and clock enable latch nothing
		wb(1'b1, 8'h00, 32'h0000_0000);
		repeat (200) begin
			{ce, pwm, fly, oc, ot} <= 5'($urandom);
			@(posedge mclk_i);
		end
		// settle with flyback seen so re-armed open detection stays quiet
		{ce, pwm, fly, oc, ot} <= 5'h14;
		repeat (10) @(posedge mclk_i);
		wb(1'b1, 8'h00, 32'h0000_0007);
		$display("test no fault done");
		ph_q.push_back(4'h0);
		ft_q.push_back(2'h2);
		{pwm, oc} <= 2'b11;
		repeat (1200) @(posedge mclk_i);
		{pwm, oc} <= 2'b00;
		step(1'b0, 1);
		cmp("flag enable", 32'h0000_0000, {31'h0, flag_oe_n});
		rst_pulse(2'h2);
		ph_q.push_back(4'h0);
		ft_q.push_back(2'h3);
		ot <= 1'b1;
		repeat (10) @(posedge mclk_i);
		ot <= 1'b0;
		rd(8'h04, {24'h00_0000, 3'b010, idx, 2'h3});
		rst_pulse(2'h3);
		fly <= 1'b0;
		pwm <= 1'b1;
		repeat (10) @(posedge mclk_i);
		pwm <= 1'b0;
		repeat (10) @(posedge mclk_i);
		ph_q.push_back(4'h0);
		ft_q.push_back(2'h1);
		pwm <= 1'b1;
		repeat (10) @(posedge mclk_i);
		{pwm, fly} <= 2'b01;
		rst_pulse(2'h1);
		$display("test faults done");
		repeat (10) @(posedge mclk_i);
		cmp("pending notes", 32'h0000_0000, ph_q.size() + ft_q.size() + rd_q.size());
		report_and_stop();
	end
endmodule
